// ---- hw/gst_timer.sv ----
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module gst_timer (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// pins, asynchronous
	input wire logic count_input_pin,
	input wire logic gate_pin_n,
	input wire logic second_comparator_out,
	// system side, same clock
	input wire logic sleep_mode,
	input wire logic capture_event,
	input wire logic special_event_en,
	// outputs
	output logic osc_enable,
	output logic compare_event,
	output logic irq_req,
	output logic wake_req,
	output logic [15:0] resume_vector
);
	logic [7:0] ctrl_reg, awaddr_reg;
	logic [3:0] ena_reg, wstrb_reg;
	logic [15:0] count_reg, capt_reg, cmp_reg;
	logic [2:0] presc_reg, ext_sync_reg;
	logic [1:0] instr_div_reg, gate_sync_reg, comp_sync_reg, bresp_reg, rresp_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic flag_reg, ext_rise_d_reg, armed_reg, match_reg, cmp_evt_reg;
	logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;

	logic wr_do, wr_lo, wr_hi, cnt_wr, async_mode;
	logic ext_rise, ext_fall, src_tick, gate_level, gate_open;
	logic run, presc_hit, inc, sev_clear;
	logic [2:0] presc_last;

	localparam int ADDR_MSB_L = gst_pkg::ADDR_MSB;
	localparam int ADDR_LSB_L = gst_pkg::ADDR_LSB;
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = a[ADDR_MSB_L:ADDR_LSB_L] == off[ADDR_MSB_L:ADDR_LSB_L];
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, gst_pkg::CTRL_OFF) || hit(a, gst_pkg::CNT_LO_OFF) ||
			hit(a, gst_pkg::CNT_HI_OFF) || hit(a, gst_pkg::FLAG_OFF) ||
			hit(a, gst_pkg::ENA_OFF) || hit(a, gst_pkg::CAPT_OFF) ||
			hit(a, gst_pkg::CMP_OFF);
	endfunction

	// ---------------- bus slave ----------------
	assign awready = !aw_hold_reg && !bvalid_reg;
	assign wready = !w_hold_reg && !bvalid_reg;
	assign arready = !rvalid_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign wr_do = aw_hold_reg && w_hold_reg;
	assign wr_lo = wr_do && wstrb_reg[0] && hit(awaddr_reg, gst_pkg::CNT_LO_OFF);
	assign wr_hi = wr_do && wstrb_reg[0] && hit(awaddr_reg, gst_pkg::CNT_HI_OFF);
	assign cnt_wr = wr_lo || wr_hi;

	// address and data may arrive in either order; each is held until both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= awaddr[7:0];
			end else if (wr_do) begin
				aw_hold_reg <= 1'b0;
			end
			if (wvalid && wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end else if (wr_do) begin
				w_hold_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= gst_pkg::RESP_OKAY;
		end else if (wr_do) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= mapped(awaddr_reg) ? gst_pkg::RESP_OKAY : gst_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// counter is in this clock domain, so a byte read never tears
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= gst_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= mapped(araddr[7:0]) ? gst_pkg::RESP_OKAY : gst_pkg::RESP_SLVERR;
			rdata_reg <= 32'h00000000;
			if (hit(araddr[7:0], gst_pkg::CTRL_OFF))
				rdata_reg[7:0] <= ctrl_reg;
			if (hit(araddr[7:0], gst_pkg::CNT_LO_OFF))
				rdata_reg[7:0] <= count_reg[7:0];
			if (hit(araddr[7:0], gst_pkg::CNT_HI_OFF))
				rdata_reg[7:0] <= count_reg[15:8];
			if (hit(araddr[7:0], gst_pkg::FLAG_OFF))
				rdata_reg[0] <= flag_reg;
			if (hit(araddr[7:0], gst_pkg::ENA_OFF))
				rdata_reg[3:0] <= ena_reg;
			if (hit(araddr[7:0], gst_pkg::CAPT_OFF))
				rdata_reg[15:0] <= capt_reg;
			if (hit(araddr[7:0], gst_pkg::CMP_OFF))
				rdata_reg[15:0] <= cmp_reg;
		end else if (rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ---------------- software registers ----------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= gst_pkg::CTRL_RESET;
			ena_reg <= gst_pkg::ENA_RESET;
			cmp_reg <= gst_pkg::CNT_ZERO;
		end else if (wr_do) begin
			if (wstrb_reg[0] && hit(awaddr_reg, gst_pkg::CTRL_OFF))
				ctrl_reg <= wdata_reg[7:0];
			if (wstrb_reg[0] && hit(awaddr_reg, gst_pkg::ENA_OFF))
				ena_reg <= wdata_reg[3:0];
			if (wstrb_reg[0] && hit(awaddr_reg, gst_pkg::CMP_OFF))
				cmp_reg[7:0] <= wdata_reg[7:0];
			if (wstrb_reg[1] && hit(awaddr_reg, gst_pkg::CMP_OFF))
				cmp_reg[15:8] <= wdata_reg[15:8];
		end
	end

	assign osc_enable = ctrl_reg[gst_pkg::CTRL_OSC];

	// ---------------- input synchronisers ----------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_sync_reg <= 3'h0;
			gate_sync_reg <= 2'h3;
			comp_sync_reg <= 2'h0;
			ext_rise_d_reg <= 1'b0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], count_input_pin};
			gate_sync_reg <= {gate_sync_reg[0], gate_pin_n};
			comp_sync_reg <= {comp_sync_reg[0], second_comparator_out};
			ext_rise_d_reg <= ext_rise;
		end
	end

	assign ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
	assign ext_fall = !ext_sync_reg[1] && ext_sync_reg[2];

	// no edge is counted until a falling edge has been seen while counting is set up
	always_ff @(posedge aclk) begin
		if (!aresetn)
			armed_reg <= 1'b0;
		else if (!ctrl_reg[gst_pkg::CTRL_ON] || !ctrl_reg[gst_pkg::CTRL_CS])
			armed_reg <= 1'b0;
		else if (ext_fall)
			armed_reg <= 1'b1;
	end

	// ---------------- clock selection and gating ----------------
	assign async_mode = ctrl_reg[gst_pkg::CTRL_CS] && ctrl_reg[gst_pkg::CTRL_SYNC];

	// the synchronised path adds one stage, like sampling on the phase clocks;
	// changing the bypass bit mid-edge may skip or repeat one count
	always_comb begin
		if (!ctrl_reg[gst_pkg::CTRL_CS])
			src_tick = (instr_div_reg == gst_pkg::INSTR_DIV_LAST) && !sleep_mode;
		else if (ctrl_reg[gst_pkg::CTRL_SYNC])
			src_tick = ext_rise && armed_reg;
		else
			src_tick = ext_rise_d_reg && armed_reg && !sleep_mode;
	end

	assign gate_level = ena_reg[gst_pkg::ENA_GSS] ? comp_sync_reg[1] : gate_sync_reg[1];
	assign gate_open = gate_level == ctrl_reg[gst_pkg::CTRL_POL];
	// only the asynchronous path keeps running while the core sleeps
	assign run = ctrl_reg[gst_pkg::CTRL_ON] && (!ctrl_reg[gst_pkg::CTRL_GE] || gate_open) &&
		(!sleep_mode || async_mode);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			instr_div_reg <= 2'h0;
		else
			instr_div_reg <= instr_div_reg + 2'h1;
	end

	// ---------------- prescaler ----------------
	always_comb begin
		case (ctrl_reg[gst_pkg::CTRL_PS_HI:gst_pkg::CTRL_PS_LO])
			gst_pkg::PS_DIV1: presc_last = gst_pkg::PRESC_LAST_DIV1;
			gst_pkg::PS_DIV2: presc_last = gst_pkg::PRESC_LAST_DIV2;
			gst_pkg::PS_DIV4: presc_last = gst_pkg::PRESC_LAST_DIV4;
			default: presc_last = gst_pkg::PRESC_LAST_DIV8;
		endcase
	end

	assign presc_hit = presc_reg == presc_last;
	assign inc = run && src_tick && presc_hit && !cnt_wr;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			presc_reg <= gst_pkg::PRESC_ZERO;
		else if (cnt_wr)
			presc_reg <= gst_pkg::PRESC_ZERO;
		else if (run && src_tick)
			presc_reg <= presc_hit ? gst_pkg::PRESC_ZERO : presc_reg + 3'h1;
	end

	// ---------------- counter ----------------
	assign sev_clear = cmp_evt_reg && special_event_en;

	// a byte write simply wins over an increment; software is expected to stop first
	always_ff @(posedge aclk) begin
		if (!aresetn)
			count_reg <= gst_pkg::CNT_ZERO;
		else if (wr_lo)
			count_reg[7:0] <= wdata_reg[7:0];
		else if (wr_hi)
			count_reg[15:8] <= wdata_reg[7:0];
		else if (sev_clear)
			count_reg <= gst_pkg::CNT_ZERO;
		else if (inc)
			count_reg <= count_reg + 16'h0001;
	end

	// set beats a software clear in the same cycle; clear writes a zero
	always_ff @(posedge aclk) begin
		if (!aresetn)
			flag_reg <= 1'b0;
		else if (inc && count_reg == gst_pkg::CNT_MAX && !sev_clear)
			flag_reg <= 1'b1;
		else if (wr_do && wstrb_reg[0] && hit(awaddr_reg, gst_pkg::FLAG_OFF))
			flag_reg <= wdata_reg[gst_pkg::FLAG_ROLL];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			capt_reg <= gst_pkg::CNT_ZERO;
		else if (capture_event)
			capt_reg <= count_reg;
	end

	// one pulse when the counter arrives at the compare value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_reg <= 1'b0;
			cmp_evt_reg <= 1'b0;
		end else begin
			match_reg <= count_reg == cmp_reg;
			cmp_evt_reg <= (count_reg == cmp_reg) && !match_reg;
		end
	end

	assign compare_event = cmp_evt_reg;
	// enables and flag are registers, so irq_req stays glitch free; wake_req also follows the sleep_mode input
	assign irq_req = flag_reg && ena_reg[gst_pkg::ENA_ROLL] && ena_reg[gst_pkg::ENA_PERIPH] &&
		ena_reg[gst_pkg::ENA_GLOBAL];
	assign wake_req = flag_reg && ena_reg[gst_pkg::ENA_ROLL] && ena_reg[gst_pkg::ENA_PERIPH] &&
		ctrl_reg[gst_pkg::CTRL_ON] && sleep_mode;
	assign resume_vector = ena_reg[gst_pkg::ENA_GLOBAL] ? gst_pkg::ISR_VECTOR : gst_pkg::CNT_ZERO;

	// ---------------- checks ----------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_wrap_flag;
		inc && count_reg == gst_pkg::CNT_MAX && !sev_clear |=>
			flag_reg && count_reg == gst_pkg::CNT_ZERO;
	endproperty
	a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag");

	property p_irq_needs_all;
		irq_req |-> flag_reg && ena_reg[gst_pkg::ENA_GLOBAL] && ena_reg[gst_pkg::ENA_PERIPH];
	endproperty
	a_irq_needs_all: assert property (p_irq_needs_all) else $error("irq without enables");

	property p_flag_sticky;
		flag_reg && !wr_do |=> flag_reg;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself");

	property p_off_holds;
		!ctrl_reg[gst_pkg::CTRL_ON] && !cnt_wr && !sev_clear |=> $stable(count_reg);
	endproperty
	a_off_holds: assert property (p_off_holds) else $error("counter moved while off");

	property p_gate_blocks;
		ctrl_reg[gst_pkg::CTRL_ON] && ctrl_reg[gst_pkg::CTRL_GE] && !gate_open && !cnt_wr &&
			!sev_clear |=> $stable(count_reg);
	endproperty
	a_gate_blocks: assert property (p_gate_blocks) else $error("closed gate let count");

	property p_sev_clear;
		sev_clear && !cnt_wr |=> count_reg == gst_pkg::CNT_ZERO && !$rose(flag_reg);
	endproperty
	a_sev_clear: assert property (p_sev_clear) else $error("special clear wrong");

	property p_write_wins;
		sev_clear && wr_lo |=> count_reg[7:0] == $past(wdata_reg[7:0]);
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("clear beat a write");

	property p_presc_clear;
		cnt_wr |=> presc_reg == gst_pkg::PRESC_ZERO;
	endproperty
	a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

	property p_sleep_sync;
		sleep_mode && !async_mode && !cnt_wr && !sev_clear |=> $stable(count_reg);
	endproperty
	a_sleep_sync: assert property (p_sleep_sync) else $error("sync count in sleep");

	property p_capture;
		capture_event |=> capt_reg == $past(count_reg);
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed value");

	property p_unarmed;
		ctrl_reg[gst_pkg::CTRL_CS] && !armed_reg && !cnt_wr && !sev_clear |=> $stable(count_reg);
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("count before falling edge");

	property p_div8;
		inc && ctrl_reg[gst_pkg::CTRL_PS_HI:gst_pkg::CTRL_PS_LO] == gst_pkg::PS_DIV8 &&
			!ctrl_reg[gst_pkg::CTRL_CS]
			&& $stable(ctrl_reg) |=> !inc [*8];
	endproperty
	a_div8: assert property (p_div8) else $error("divide by eight too fast");

	c_wrap: cover property (inc && count_reg == gst_pkg::CNT_MAX);
	c_sev: cover property (sev_clear);
	c_capture: cover property (capture_event && count_reg != gst_pkg::CNT_ZERO);
	c_wake: cover property ($rose(wake_req));
endmodule
`default_nettype wire

// ---- inc/gst_pkg.sv ----
package gst_pkg;
	// register byte addresses
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] CNT_LO_OFF = 8'h04;
	localparam logic [7:0] CNT_HI_OFF = 8'h08;
	localparam logic [7:0] FLAG_OFF = 8'h0C;
	localparam logic [7:0] ENA_OFF = 8'h10;
	localparam logic [7:0] CAPT_OFF = 8'h14;
	localparam logic [7:0] CMP_OFF = 8'h18;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 7;
	// counter_control_reg fields
	localparam int CTRL_ON = 0;
	localparam int CTRL_CS = 1;
	localparam int CTRL_SYNC = 2;
	localparam int CTRL_OSC = 3;
	localparam int CTRL_PS_LO = 4;
	localparam int CTRL_PS_HI = 5;
	localparam int CTRL_GE = 6;
	localparam int CTRL_POL = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// flag and enable register fields
	localparam int FLAG_ROLL = 0;
	localparam int ENA_ROLL = 0;
	localparam int ENA_PERIPH = 1;
	localparam int ENA_GLOBAL = 2;
	localparam int ENA_GSS = 3;
	localparam logic [3:0] ENA_RESET = 4'h0;
	// counter
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] ISR_VECTOR = 16'h0004;
	// instruction clock is the bus clock divided by four
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
	localparam logic [1:0] PS_DIV1 = 2'h0;
	localparam logic [1:0] PS_DIV2 = 2'h1;
	localparam logic [1:0] PS_DIV4 = 2'h2;
	localparam logic [1:0] PS_DIV8 = 2'h3;
	localparam logic [2:0] PRESC_ZERO = 3'h0;
	// last prescaler count before an increment, per divide ratio
	localparam logic [2:0] PRESC_LAST_DIV1 = 3'h0;
	localparam logic [2:0] PRESC_LAST_DIV2 = 3'h1;
	localparam logic [2:0] PRESC_LAST_DIV4 = 3'h3;
	localparam logic [2:0] PRESC_LAST_DIV8 = 3'h7;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- tb/gst_pins_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module gst_pins_model (
	// pins toward the timer
	output logic count_input_pin,
	output logic gate_pin_n,
	output logic second_comparator_out
);
	// count clock starts low; an even number of toggles leaves it at the level it had
	initial count_input_pin = 1'b0;
	initial gate_pin_n = 1'b1;
	initial second_comparator_out = 1'b0;

	// half period in ns, so bursts can be prompt or slow
	task automatic toggle(input int n, input int half);
		repeat (n) begin
			#(half);
			count_input_pin = ~count_input_pin;
		end
	endtask

	// gate levels only move while the counter is stopped
	task automatic set_gate(input logic pin_n, input logic cmp);
		gate_pin_n = pin_n;
		second_comparator_out = cmp;
	endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata, d;
	logic [3:0] wstrb;
	logic [2:0] awprot, arprot;
	logic [1:0] bresp, rresp, rsp;
	logic sleep_mode, capture_event, special_event_en;
	logic osc_enable, compare_event, irq_req, wake_req;
	logic [15:0] resume_vector, v, st;
	logic [7:0] c;
	wire logic count_input_pin, gate_pin_n, second_comparator_out;
	int err_count = 0;
	int comparisons = 0;
	int cmp_seen = 0;
	int n, k, hp;

	gst_timer u_gst_timer (
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.count_input_pin(count_input_pin), .gate_pin_n(gate_pin_n),
		.second_comparator_out(second_comparator_out),
		.sleep_mode(sleep_mode), .capture_event(capture_event),
		.special_event_en(special_event_en),
		.osc_enable(osc_enable), .compare_event(compare_event), .irq_req(irq_req),
		.wake_req(wake_req), .resume_vector(resume_vector)
	);
	gst_pins_model u_gst_pins_model (
		.count_input_pin(count_input_pin),
		.gate_pin_n(gate_pin_n),
		.second_comparator_out(second_comparator_out)
	);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (compare_event === 1'b1) begin
			cmp_seen <= cmp_seen + 1;
		end
	end

	function automatic int exp_ticks(input int cyc, input int p);
		return cyc / (4 << p);
	endfunction

	// first burst after reset loses its leading rise; sync mode freezes in sleep
	function automatic int exp_ext(input int s, input int kk);
		if (s == 2) begin
			return 0;
		end
		return (s == 0) ? kk - 1 : kk;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic near(input logic [15:0] got, input int lo_e, input int hi_e);
		comparisons++;
		if (((got >= lo_e) && (got <= hi_e)) !== 1'b1) begin
			err_count++;
			$display("Error at %0t: count %h outside %0d..%0d", $time, got, lo_e, hi_e);
		end
	endtask

	// ready is combinational on registers, so a sample 1 ns after the edge holds at the next
	task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] r);
		logic ta, tw, tb;
		tb = 1'b0;
		awaddr <= {24'h000000, a};
		wdata <= dv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!tb) begin
			#1;
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) begin
				awvalid <= 1'b0;
			end
			if (tw) begin
				wvalid <= 1'b0;
			end
		end
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] dv);
		logic [1:0] r;
		wr(a, dv, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] r);
		logic ta, tr;
		tr = 1'b0;
		araddr <= {24'h000000, a};
		arvalid <= 1'b1;
		while (!tr) begin
			#1;
			ta = arvalid & arready;
			tr = rvalid;
			dv = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) begin
				arvalid <= 1'b0;
			end
		end
	endtask

	task automatic rdv(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] dv;
		logic [1:0] r;
		rd(a, dv, r);
		chk(dv, exp);
	endtask

	task automatic run_cnt(input logic [7:0] ctl, input logic [15:0] s0, input int cyc,
		input int tog, input int half, output logic [15:0] fin);
		logic [31:0] lo, hi;
		logic [1:0] r;
		w(gst_pkg::CNT_HI_OFF, {24'h000000, s0[15:8]});
		w(gst_pkg::CNT_LO_OFF, {24'h000000, s0[7:0]});
		w(gst_pkg::CTRL_OFF, {24'h000000, ctl});
		if (tog > 0) begin
			u_gst_pins_model.toggle(tog, half);
		end
		repeat (cyc) @(posedge aclk);
		w(gst_pkg::CTRL_OFF, {24'h000000, ctl & 8'hFE});
		rd(gst_pkg::CNT_LO_OFF, lo, r);
		rd(gst_pkg::CNT_HI_OFF, hi, r);
		fin = {hi[7:0], lo[7:0]};
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge aclk);
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		print_verdict();
	end

	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		bready = 1'b1;
		rready = 1'b1;
		awaddr = 32'h00000000;
		wdata = 32'h00000000;
		araddr = 32'h00000000;
		wstrb = 4'hF;
		awprot = 3'h0;
		arprot = 3'h0;
		sleep_mode = 1'b0;
		capture_event = 1'b0;
		special_event_en = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		void'($urandom(32'h9acf));
		rdv(gst_pkg::CTRL_OFF, 32'h0);
		rdv(gst_pkg::FLAG_OFF, 32'h0);
		rdv(gst_pkg::ENA_OFF, 32'h0);
		chk(resume_vector, 32'h0);
		wr(8'h1C, 32'hFFFFFFFF, rsp);
		chk(rsp, gst_pkg::RESP_SLVERR);
		rd(8'h1C, d, rsp);
		chk({d[31:2], rsp}, {30'h0, gst_pkg::RESP_SLVERR});
		$display("test registers done");
		for (int p = 0; p < 4; p++) begin
			c = (8'($urandom) & 8'h0C) | {2'b00, 2'(p), 4'h1};
			n = $urandom_range(511, 256);
			st = 16'(8'($urandom));
			run_cnt(c, st, n, 0, 0, v);
			near(v - st, exp_ticks(n, p) - 1, exp_ticks(n, p) + 2);
			chk(osc_enable, c[3]);
			rdv(gst_pkg::CTRL_OFF, {24'h0, c & 8'hFE});
		end
		$display("test prescale done");
		for (int g = 0; g < 8; g++) begin
			w(gst_pkg::ENA_OFF, g[2] ? 32'h8 : 32'h0);
			// the unselected source shows the opposite level to catch a wrong pick
			u_gst_pins_model.set_gate(g[0] ^ g[2], ~(g[0] ^ g[2]));
			run_cnt({g[1], 7'h41}, 16'h0000, 200, 0, 0, v);
			if (g[0] == g[1]) begin
				near(v, 49, 52);
			end else begin
				near(v, 0, 0);
			end
		end
		w(gst_pkg::ENA_OFF, 32'h0);
		$display("test gate done");
		for (int s = 0; s < 4; s++) begin
			k = $urandom_range(8, 3);
			hp = $urandom_range(200, 60);
			if (s == 1) begin
				u_gst_pins_model.toggle(1, hp);
				@(posedge aclk);
			end
			sleep_mode <= s[1];
			st = 16'($urandom);
			run_cnt({5'h00, s[0], 2'h3}, st, 8, 2 * k, hp, v);
			near(v - st, exp_ext(s, k), exp_ext(s, k));
		end
		sleep_mode <= 1'b0;
		$display("test external done");
		w(gst_pkg::FLAG_OFF, 32'h0);
		run_cnt(8'h01, 16'hFFF0, 100, 0, 0, v);
		near(v, 6, 14);
		rdv(gst_pkg::FLAG_OFF, 32'h1);
		sleep_mode <= 1'b1;
		w(gst_pkg::CTRL_OFF, 32'h1);
		for (int e = 0; e < 8; e++) begin
			w(gst_pkg::ENA_OFF, 32'(e));
			chk(irq_req, e == 7);
			chk(wake_req, e[0] & e[1]);
			chk(resume_vector, e[2] ? 32'h4 : 32'h0);
		end
		rdv(gst_pkg::FLAG_OFF, 32'h1);
		w(gst_pkg::FLAG_OFF, 32'h0);
		chk(irq_req, 1'b0);
		rdv(gst_pkg::FLAG_OFF, 32'h0);
		sleep_mode <= 1'b0;
		w(gst_pkg::CTRL_OFF, 32'h0);
		w(gst_pkg::ENA_OFF, 32'h0);
		$display("test rollover done");
		v = 16'($urandom);
		w(gst_pkg::CNT_HI_OFF, {24'h0, v[15:8]});
		w(gst_pkg::CNT_LO_OFF, {24'h0, v[7:0]});
		capture_event <= 1'b1;
		@(posedge aclk);
		capture_event <= 1'b0;
		@(posedge aclk);
		rdv(gst_pkg::CAPT_OFF, {16'h0, v});
		w(gst_pkg::CMP_OFF, 32'h10);
		rdv(gst_pkg::CMP_OFF, 32'h10);
		special_event_en <= 1'b1;
		n = cmp_seen;
		// internal clock keeps the trigger synchronous
		run_cnt(8'h01, 16'h0000, 300, 0, 0, v);
		near(v, 0, 16);
		chk(cmp_seen - n >= 3, 1'b1);
		rdv(gst_pkg::FLAG_OFF, 32'h0);
		special_event_en <= 1'b0;
		$display("test capture compare done");
		print_verdict();
	end
endmodule
`default_nettype wire
